// ===== core/rwsp_pkg.sv
package rwsp_pkg;
   // register addresses on the control port
   localparam logic [7:0] ADDR_PROGRAM_INDEX = 8'h6C;
   localparam logic [7:0] ADDR_STEP_TARGET   = 8'h6D;
   localparam logic [7:0] ADDR_STEP_PAYLOAD  = 8'h6E;
   localparam logic [7:0] ADDR_RUN_CONTROL   = 8'h6F;
   localparam logic [7:0] ADDR_RUN_STATUS    = 8'h70;
   localparam logic [7:0] ADDR_DUMMY         = 8'hFF;

   // program index register fields
   localparam int PIDX_INDEX_LSB = 0;
   localparam int PIDX_INDEX_W   = 5;
   localparam int PIDX_CLKON_BIT = 8;

   // step target descriptor fields
   localparam int TGT_ADDR_LSB  = 0;
   localparam int TGT_ADDR_W    = 8;
   localparam int TGT_START_LSB = 8;
   localparam int TGT_START_W   = 4;
   localparam int TGT_WIDTH_LSB = 12;
   localparam int TGT_WIDTH_W   = 3;

   // step payload descriptor fields
   localparam int PAY_DATA_LSB  = 0;
   localparam int PAY_DATA_W    = 8;
   localparam int PAY_DELAY_LSB = 8;
   localparam int PAY_DELAY_W   = 4;
   localparam int PAY_LAST_BIT  = 15;

   // run control and status fields
   localparam int RUN_ENTRY_LSB  = 0;
   localparam int RUN_ENTRY_W    = 6;
   localparam int RUN_TRIG_BIT   = 8;
   localparam int RUN_CANCEL_BIT = 9;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_CUR_LSB   = 4;

   // memory layout
   localparam int RAM_ENTRIES          = 32;
   localparam logic [5:0] ROM_FIRST    = 6'h20;
   localparam logic [5:0] ROM_LAST     = 6'h30;
   localparam logic [15:0] ROM_TARGET  = 16'h00FF;
   localparam logic [15:0] ROM_PAYLOAD = 16'h8000;

   // step timing: delay unit and extra units per step
   localparam real TICK_US           = 62.5;
   localparam real CLOCK_MHZ         = 100.0;
   localparam int  TICK_CYCLES       = int'(TICK_US * CLOCK_MHZ);
   localparam logic [15:0] STEP_BASE = 16'h0008;

   localparam logic [15:0] RESET_HALF = 16'h0000;
endpackage

// ===== core/rwsp_timebase.sv
`timescale 1ns/1ps
// divider, held at zero while not running, giving one enable pulse per delay unit
module rwsp_timebase #(
   parameter int DIVIDE = rwsp_pkg::TICK_CYCLES
) (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   output logic      tick_o
);
   localparam int CW = $clog2(DIVIDE + 1);
   logic [CW-1:0] count_r;

   generate
      if (DIVIDE < 2) begin : g_bad
         $error("rwsp_timebase: DIVIDE must be at least 2");
      end
   endgenerate

   // restart from zero whenever stopped so each step gets whole units
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         count_r <= '0;
      end else if (!run_i || count_r == CW'(DIVIDE - 1)) begin
         count_r <= '0;
      end else begin
         count_r <= count_r + 1'b1;
      end
   end

   assign tick_o = run_i && (count_r == CW'(DIVIDE - 1));
endmodule // rwsp_timebase

// ===== core/rwsp_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - five-bit program index selects RAM entry 0-31
// - entries 32-48 are fixed, not programmable
// - descriptor writes land in selected entry
// - target address in descriptor bits 7:0
// - start field 11:8 gives field LSB
// - width field 14:12 means code plus one
// - only the selected field bits change
// - payload 7:0, bits above width ignored
// - step time 62.5us times (2^D+8)
// - last-step flag stops, else next entry
// - zero to bit 0 of FFh changes nothing
// - run trigger starts at run entry index
// - self-clearing trigger; busy blocks host writes
// - cancel stops at once, host regains control
// - sequence end raises completion flag
module rwsp_sequencer #(
   parameter int TICK_DIVIDE = rwsp_pkg::TICK_CYCLES
) (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        core_clock_on_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_we_i,
   input  wire logic        reg_re_i,
   output logic      [15:0] reg_rdata_o,
   output logic             host_ctl_we_o,
   output logic             ctl_we_o,
   output logic      [7:0]  ctl_addr_o,
   output logic      [15:0] ctl_mask_o,
   output logic      [15:0] ctl_data_o,
   output logic             runner_active_flag_o,
   output logic             run_done_flag_o
);
   typedef enum logic [1:0] {RWSP_IDLE, RWSP_WRITE, RWSP_WAIT} rwsp_state_type;

   rwsp_state_type state_r;
   logic [15:0] target_mem [rwsp_pkg::RAM_ENTRIES];
   logic [15:0] payload_mem [rwsp_pkg::RAM_ENTRIES];
   logic [4:0]  program_entry_index_r;
   logic        runner_clock_on_r;
   logic [5:0]  run_entry_index_r;
   logic [5:0]  current_index_r;
   logic [15:0] units_r;
   logic        tick;
   logic        busy;
   logic        seq_reg;
   logic        wr_trig;
   logic        wr_cancel;
   logic [15:0] cur_target;
   logic [15:0] cur_payload;
   logic [7:0]  step_target_address;
   logic [3:0]  step_lsb_position;
   logic [2:0]  step_field_width;
   logic [7:0]  step_payload;
   logic [3:0]  step_delay_code;
   logic        last_step_flag;
   logic [23:0] wide_mask;
   logic [23:0] wide_data;
   logic [7:0]  low_mask;

   assign busy = (state_r != RWSP_IDLE);
   assign runner_active_flag_o = busy;
   assign seq_reg = (reg_addr_i >= rwsp_pkg::ADDR_PROGRAM_INDEX) && (reg_addr_i <= rwsp_pkg::ADDR_RUN_STATUS);
   assign wr_trig = reg_we_i && (reg_addr_i == rwsp_pkg::ADDR_RUN_CONTROL) && reg_wdata_i[rwsp_pkg::RUN_TRIG_BIT];
   assign wr_cancel = reg_we_i && (reg_addr_i == rwsp_pkg::ADDR_RUN_CONTROL)
                      && reg_wdata_i[rwsp_pkg::RUN_CANCEL_BIT];

   // host writes to ordinary control registers are let through only while idle
   assign host_ctl_we_o = reg_we_i && !seq_reg && !busy;

   rwsp_timebase #(
      .DIVIDE (TICK_DIVIDE)
   ) u_timebase (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .run_i   (busy && runner_clock_on_r && core_clock_on_i),
      .tick_o  (tick)
   );

   // descriptor RAM has no reset so programmed steps survive a soft reset
   always_ff @(posedge clock_i) begin
      if (reg_we_i && reg_addr_i == rwsp_pkg::ADDR_STEP_TARGET) begin
         target_mem[program_entry_index_r] <= reg_wdata_i;
      end
      if (reg_we_i && reg_addr_i == rwsp_pkg::ADDR_STEP_PAYLOAD) begin
         payload_mem[program_entry_index_r] <= reg_wdata_i;
      end
   end

   // fixed entries come from constants and ignore the programming registers
   always_comb begin
      if (current_index_r < 6'(rwsp_pkg::RAM_ENTRIES)) begin
         cur_target  = target_mem[current_index_r[4:0]];
         cur_payload = payload_mem[current_index_r[4:0]];
      end else begin
         cur_target  = rwsp_pkg::ROM_TARGET;
         cur_payload = rwsp_pkg::ROM_PAYLOAD;
      end
   end

   // descriptor field split
   assign step_target_address = cur_target[rwsp_pkg::TGT_ADDR_LSB +: rwsp_pkg::TGT_ADDR_W];
   assign step_lsb_position   = cur_target[rwsp_pkg::TGT_START_LSB +: rwsp_pkg::TGT_START_W];
   assign step_field_width    = cur_target[rwsp_pkg::TGT_WIDTH_LSB +: rwsp_pkg::TGT_WIDTH_W];
   assign step_payload        = cur_payload[rwsp_pkg::PAY_DATA_LSB +: rwsp_pkg::PAY_DATA_W];
   assign step_delay_code     = cur_payload[rwsp_pkg::PAY_DELAY_LSB +: rwsp_pkg::PAY_DELAY_W];
   assign last_step_flag      = cur_payload[rwsp_pkg::PAY_LAST_BIT];

   // field mask built wide, then cut to 16 bits so overflow bits simply vanish
   assign low_mask  = 8'((9'h002 << step_field_width) - 9'h001);
   assign wide_mask = 24'({16'h0000, low_mask} << step_lsb_position);
   assign wide_data = 24'({16'h0000, step_payload & low_mask} << step_lsb_position);

   // program index and runner clock enable
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         program_entry_index_r <= 5'h00;
         runner_clock_on_r     <= 1'b0;
      end else if (reg_we_i && reg_addr_i == rwsp_pkg::ADDR_PROGRAM_INDEX) begin
         program_entry_index_r <= reg_wdata_i[rwsp_pkg::PIDX_INDEX_LSB +: rwsp_pkg::PIDX_INDEX_W];
         runner_clock_on_r     <= reg_wdata_i[rwsp_pkg::PIDX_CLKON_BIT];
      end
   end

   // start index is stored on any run control write made while idle
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         run_entry_index_r <= 6'h00;
      end else if (reg_we_i && reg_addr_i == rwsp_pkg::ADDR_RUN_CONTROL && !busy) begin
         run_entry_index_r <= reg_wdata_i[rwsp_pkg::RUN_ENTRY_LSB +: rwsp_pkg::RUN_ENTRY_W];
      end
   end

   // step engine; reserved start indices 49-63 are refused and nothing runs
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_r         <= RWSP_IDLE;
         current_index_r <= 6'h00;
         units_r         <= 16'h0000;
      end else if (wr_cancel) begin
         state_r <= RWSP_IDLE;
      end else begin
         unique case (state_r)
            RWSP_IDLE: begin
               if (wr_trig
                   && reg_wdata_i[rwsp_pkg::RUN_ENTRY_LSB +: rwsp_pkg::RUN_ENTRY_W] <= rwsp_pkg::ROM_LAST) begin
                  current_index_r <= reg_wdata_i[rwsp_pkg::RUN_ENTRY_LSB +: rwsp_pkg::RUN_ENTRY_W];
                  state_r         <= RWSP_WRITE;
               end
            end
            RWSP_WRITE: begin
               units_r <= (16'h0001 << step_delay_code) + rwsp_pkg::STEP_BASE;
               state_r <= RWSP_WAIT;
            end
            RWSP_WAIT: begin
               if (tick && units_r <= 16'h0001) begin
                  if (last_step_flag || current_index_r == rwsp_pkg::ROM_LAST) begin
                     state_r <= RWSP_IDLE;
                  end else begin
                     current_index_r <= current_index_r + 6'h01;
                     state_r         <= RWSP_WRITE;
                  end
               end else if (tick) begin
                  units_r <= units_r - 16'h0001;
               end
            end
         endcase
      end
   end

   // one masked write per step; the dummy address never reaches the registers
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_we_o   <= 1'b0;
         ctl_addr_o <= 8'h00;
         ctl_mask_o <= rwsp_pkg::RESET_HALF;
         ctl_data_o <= rwsp_pkg::RESET_HALF;
      end else begin
         ctl_we_o <= (state_r == RWSP_WRITE) && !wr_cancel
                     && (step_target_address != rwsp_pkg::ADDR_DUMMY);
         if (state_r == RWSP_WRITE) begin
            ctl_addr_o <= step_target_address;
            ctl_mask_o <= wide_mask[15:0];
            ctl_data_o <= wide_data[15:0];
         end
      end
   end

   // completion pulse only on a natural end, not on cancel
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         run_done_flag_o <= 1'b0;
      end else begin
         run_done_flag_o <= !wr_cancel && (state_r == RWSP_WAIT) && tick && (units_r <= 16'h0001)
                            && (last_step_flag || current_index_r == rwsp_pkg::ROM_LAST);
      end
   end

   // register read data, one cycle after the read strobe
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_re_i) begin
         unique case (reg_addr_i)
            rwsp_pkg::ADDR_PROGRAM_INDEX: reg_rdata_o <= {7'h00, runner_clock_on_r, 3'h0, program_entry_index_r};
            rwsp_pkg::ADDR_STEP_TARGET:   reg_rdata_o <= target_mem[program_entry_index_r];
            rwsp_pkg::ADDR_STEP_PAYLOAD:  reg_rdata_o <= payload_mem[program_entry_index_r];
            rwsp_pkg::ADDR_RUN_CONTROL:   reg_rdata_o <= {7'h00, busy, 2'h0, run_entry_index_r};
            rwsp_pkg::ADDR_RUN_STATUS:    reg_rdata_o <= {6'h00, current_index_r, 3'h0, busy};
            default:                      reg_rdata_o <= 16'h0000;
         endcase
      end
   end
endmodule // rwsp_sequencer

// ===== verif/rwsp_monitor.sv
`timescale 1ns/1ps
// port-level checks on run control and the shape of each sequencer write
module rwsp_monitor (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_we_i,
   input  wire logic        host_ctl_we_o,
   input  wire logic        ctl_we_o,
   input  wire logic [7:0]  ctl_addr_o,
   input  wire logic [15:0] ctl_mask_o,
   input  wire logic [15:0] ctl_data_o,
   input  wire logic        runner_active_flag_o,
   input  wire logic        run_done_flag_o
);
   localparam logic [7:0] RC = rwsp_pkg::ADDR_RUN_CONTROL;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // a legal start: idle, trigger set, no cancel, index not reserved
   sequence s_start_req;
      reg_we_i && reg_addr_i == RC && reg_wdata_i[8] && !reg_wdata_i[9] && reg_wdata_i[5:0] <= 6'd48
         && !runner_active_flag_o;
   endsequence
   sequence s_cancel_req;
      reg_we_i && reg_addr_i == RC && reg_wdata_i[9] && runner_active_flag_o;
   endsequence
   a_start_sets_busy: assert property (s_start_req |=> runner_active_flag_o)
      else $error("start did not raise busy");
   a_cancel_stops_run: assert property (s_cancel_req |=> !runner_active_flag_o && !run_done_flag_o)
      else $error("cancel did not stop cleanly");
   a_done_ends_busy: assert property (run_done_flag_o |-> !runner_active_flag_o && $past(runner_active_flag_o))
      else $error("done without end of run");
   a_done_one_cycle: assert property (run_done_flag_o |=> !run_done_flag_o)
      else $error("done pulse too long");
   a_host_write_blocked: assert property (runner_active_flag_o |-> !host_ctl_we_o)
      else $error("host write passed while busy");
   a_dummy_suppressed: assert property (ctl_we_o |-> ctl_addr_o != 8'hFF)
      else $error("write to dummy address");
   a_data_within_mask: assert property (ctl_we_o |-> (ctl_data_o & ~ctl_mask_o) == 16'h0000)
      else $error("data outside field");
   a_mask_shape_ok: assert property (ctl_we_o |-> ctl_mask_o != 16'h0000 && $countones(ctl_mask_o) <= 8
      && ((ctl_mask_o + (ctl_mask_o & -ctl_mask_o)) & ctl_mask_o) == 16'h0000) else $error("bad field mask");
   a_write_while_busy: assert property (ctl_we_o |-> $past(runner_active_flag_o))
      else $error("write while idle");
endmodule // rwsp_monitor
bind rwsp_sequencer rwsp_monitor u_monitor (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .host_ctl_we_o,
   .ctl_we_o, .ctl_addr_o, .ctl_mask_o, .ctl_data_o, .runner_active_flag_o, .run_done_flag_o);

// ===== verif/tb_register_write_sequencer_program.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module tb_register_write_sequencer_program;
   logic        clock_i = 0, rst_i = 1, reg_we_i = 0, reg_re_i = 0, core_clock_on_i = 1;
   logic [7:0]  reg_addr_i = 0, ctl_addr_o;
   logic [15:0] reg_wdata_i = 0, reg_rdata_o, ctl_mask_o, ctl_data_o, v, tg[3], pl[3];
   logic        host_ctl_we_o, ctl_we_o, runner_active_flag_o, run_done_flag_o;
   int          err_total = 0, checks = 0, cyc = 0, done_n = 0, done_t = 0, tq[$];
   logic [39:0] wq[$], ew;
   localparam int TD = 4; // short delay unit keeps runs brief
   always #5 clock_i = ~clock_i;
   rwsp_sequencer #(.TICK_DIVIDE(TD)) dut (.clock_i, .rst_i, .core_clock_on_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
      .reg_re_i, .reg_rdata_o, .host_ctl_we_o, .ctl_we_o, .ctl_addr_o, .ctl_mask_o, .ctl_data_o,
      .runner_active_flag_o, .run_done_flag_o);
   // log sequencer writes and done pulses where outputs are settled
   always @(negedge clock_i) begin
      cyc++;
      if (ctl_we_o === 1'b1) begin
         wq.push_back({ctl_addr_o, ctl_mask_o, ctl_data_o});
         tq.push_back(cyc);
      end
      if (run_done_flag_o === 1'b1) begin
         done_n++;
         done_t = cyc;
      end
   end
   function automatic logic [15:0] fmask(logic [3:0] s, logic [2:0] w);
      return 16'(((32'h2 << w) - 1) << s); // bits above 15 fall away
   endfunction
   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(negedge clock_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_we_i = 1;
      @(negedge clock_i);
      reg_we_i = 0;
   endtask
   task automatic rd(logic [7:0] a);
      @(negedge clock_i);
      reg_addr_i = a;
      reg_re_i = 1;
      @(negedge clock_i);
      reg_re_i = 0;
      v = reg_rdata_o;
   endtask
   // ordinary register write; forwarded only while idle
   task automatic probe(logic e);
      @(negedge clock_i);
      reg_addr_i = 8'h05;
      reg_we_i = 1;
      #1 `CHK(host_ctl_we_o, e)
      @(negedge clock_i);
      reg_we_i = 0;
   endtask
   task automatic go(logic [5:0] i);
      wq.delete();
      tq.delete();
      wr(8'h6F, {8'h01, 2'b00, i});
   endtask
   task automatic idle;
      int n;
      n = 0;
      while (runner_active_flag_o !== 1'b0 && n < 3000) begin
         @(negedge clock_i);
         n++;
      end
      // the logger samples the done pulse on this same edge; let it run first
      #1;
      if (n == 3000) err_total++;
   endtask
   task automatic report_and_stop;
      if (err_total == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #500000;
      err_total++;
      report_and_stop;
   end
   initial begin
      void'($urandom(32'h32c183f4));
      repeat (4) @(posedge clock_i);
      @(negedge clock_i) rst_i = 0;
      // three-step programs: random field, dummy step, random last step
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 3; j++) begin
            tg[j] = {1'b0, 3'($urandom), 4'($urandom), 8'($urandom_range(0, 254))};
            pl[j] = {j == 2, 3'h0, 4'($urandom_range(0, 2)), 8'($urandom)};
         end
         if (k == 0) tg[0][14:8] = 7'h7F;
         if (k == 1) tg[0][14:8] = 7'h00;
         if (k == 1) pl[0][7:1] = 7'h00;
         // a 16-bit field split into two byte-wide steps on one register
         if (k == 2) tg[0][14:8] = 7'h70;
         if (k == 2) tg[2] = {1'b0, 3'h7, 4'h8, tg[0][7:0]};
         tg[1] = 16'h00FF;
         pl[1] = 16'h0000;
         for (int j = 0; j < 3; j++) begin
            wr(8'h6C, 16'(16'h0100 | (k * 3 + j)));
            wr(8'h6D, tg[j]);
            wr(8'h6E, pl[j]);
         end
         for (int j = 0; j < 3; j++) begin
            wr(8'h6C, 16'(16'h0100 | (k * 3 + j)));
            rd(8'h6C);
            `CHK(v, 16'(16'h0100 | (k * 3 + j)))
            rd(8'h6D);
            `CHK(v, tg[j])
            rd(8'h6E);
            `CHK(v, pl[j])
         end
         go(6'(k * 3));
         probe(1'b0);
         rd(8'h70);
         `CHK(v[0], 1'b1)
         idle;
         `CHK(wq.size(), 2)
         for (int j = 0; j < 3; j += 2) begin
            ew = {tg[j][7:0], fmask(tg[j][11:8], tg[j][14:12]), 16'h0000};
            ew[15:0] = ew[31:16] & 16'(32'(pl[j][7:0]) << tg[j][11:8]);
            `CHK(wq[j / 2], ew)
         end
         `CHK((tq[1] - tq[0] + TD / 2) / TD, (2 ** pl[0][11:8]) + 17)
         `CHK((done_t - tq[1] + TD / 2) / TD, (2 ** pl[2][11:8]) + 8)
         rd(8'h70);
         `CHK(v[9:4], 6'(k * 3 + 2))
         `CHK(done_n, k + 1)
         probe(1'b1);
      end
      // soft reset keeps the programmed steps; index and clock bit come back cleared
      @(negedge clock_i) rst_i = 1;
      @(negedge clock_i) rst_i = 0;
      rd(8'h6C);
      `CHK(v, 16'h0000)
      wr(8'h6C, 16'h010B);
      rd(8'h6D);
      `CHK(v, tg[2])
      rd(8'h6E);
      `CHK(v, pl[2])
      // with the system clock gated the step timer must not advance
      go(6'd0);
      core_clock_on_i = 0;
      repeat (60) @(negedge clock_i);
      rd(8'h70);
      `CHK(v, 16'h0001)
      core_clock_on_i = 1;
      // cancel mid-run, then a reserved start index
      repeat (6) @(negedge clock_i);
      wr(8'h6F, 16'h0200);
      `CHK(runner_active_flag_o, 1'b0)
      wr(8'h6F, 16'h0131);
      `CHK(runner_active_flag_o, 1'b0)
      rd(8'h6F);
      `CHK(v, 16'h0031)
      `CHK(done_n, 4)
      // fixed entries run without touching any register
      for (int r = 32; r < 49; r += 16) begin
         go(6'(r));
         idle;
         `CHK(wq.size(), 0)
      end
      `CHK(done_n, 6)
      report_and_stop;
   end
endmodule // tb_register_write_sequencer_program
